// *** ncc_host_ctrl.sv ***
// Purpose: Host-side controller that drives a NAND flash through its strobes on APB orders.
// Assumes: Flash inputs and ready_busy_n are synchronous to mclk.
// Notes: Each accepted write to the issue register becomes one command, address or data cycle.
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module ncc_host_ctrl
	import ncc_pkg::*;
	#(parameter int WAIT_CYC = POWER_WAIT_CYC)
	(
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output ncc_pins_s        pins,
	input  wire logic [7:0]  dataIn,
	input  wire logic        readyBusyN
	);
	ncc_state_e state, next_state;           // Strobe sequencer.
	ncc_op_s    op, next_op;                 // Cycle being driven.
	ncc_op_s    req;                         // Cycle asked for on the bus.
	ncc_pins_s  next_pins;                   // Pins for the next cycle.
	logic [7:0] rdData, next_rdData;         // Last byte read from the flash.
	logic [31:0] next_prdata;                // Read word latched in setup.
	logic       wpAllow, next_wpAllow;       // Releases write protect when set.
	logic       chipSel, next_chipSel;       // Selects the flash when set.
	logic       powerDone;                   // Supply has settled.
	logic       progOpen, next_progOpen;     // Serial input given, execute pending.
	logic       eraseOpen, next_eraseOpen;   // Erase setup given.
	logic       addrPending, next_addrPending; // Read command awaiting its address.
	logic       readMode, next_readMode;     // A read has its address.
	logic       statusMode, next_statusMode; // Status output replaced read data.
	logic       lastValid, next_lastValid;   // Page tracker holds a block.
	logic [11:0] lastBlk, next_lastBlk;      // Block last programmed.
	logic [4:0] lastPage, next_lastPage;     // Page last programmed.
	logic [1:0] partCnt, next_partCnt;       // Programs applied to that page.
	logic [1:0] region, next_region;         // Pointer region.
	logic [2:0] addrCnt, next_addrCnt;       // Address cycles since last command.
	logic [7:0] addrByte [4];                // Captured address bytes.
	logic [7:0] next_addrByte [4];           // Next captured address bytes.
	logic       rejected, next_rejected;     // Sticky refusal flag.
	logic [2:0] rejCode, next_rejCode;       // Reason for the last refusal.
	logic [2:0] rejNow;                      // Refusal reason for the current request.
	logic       wrAcc, take, acc;            // Bus write, issue taken, issue accepted.
	logic [11:0] progBlk, eraseBlk;          // Block of a program or erase address.
	logic [4:0] progPage;                    // Page of a program address.
	logic       sameBlk, badHit;             // Program hits tracked block; erase hits bad.
	logic       mapped;                      // Address decodes to a register.

	assign req      = ncc_op_s'(pwdata[ISS_W-1:0]);
	assign progBlk  = {addrByte[3][0], addrByte[2], addrByte[1][7:5]};
	assign progPage = addrByte[1][4:0];
	assign eraseBlk = {addrByte[2][0], addrByte[1], addrByte[0][7:5]};
	assign sameBlk  = lastValid && (progBlk == lastBlk);
	assign mapped   = (paddr == REG_ISSUE) || (paddr == REG_STATUS) || (paddr == REG_RDDATA)
	               || (paddr == REG_CONTROL) || (paddr == REG_BADBLK);

	// The issue register stalls the bus until the sequencer is free and power has settled.
	assign pready  = !(psel && pwrite && (paddr == REG_ISSUE)
	                   && ((state != ST_IDLE) || !powerDone));
	assign pslverr = psel && penable && !mapped;
	assign wrAcc   = psel && penable && pwrite && pready && mapped;
	assign take    = wrAcc && (paddr == REG_ISSUE);
	assign acc     = take && (rejNow == REJ_NONE);

	ncc_power_wait #(.WAIT_CYC(WAIT_CYC)) u_wait (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.done    (powerDone)
	);

	ncc_bad_blocks #(.NUM(BLOCKS), .IW(BLK_W)) u_bad (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.wrEn    (wrAcc && (paddr == REG_BADBLK)),
		.wrIdx   (pwdata[BLK_W-1:0]),
		.wrMark  (pwdata[BB_MARK]),
		.rdIdx   (eraseBlk),
		.rdMark  (badHit)
	);

	// Screen each request; the first failing check names the refusal.
	// A refused request is dropped whole, so the flash never sees a stray cycle.
	always_comb begin
		rejNow = REJ_NONE;
		if (req.kind == K_CMD) begin
			if (!cmdKnown(req.data)) begin
				rejNow = REJ_UNKNOWN;
			end else if (!readyBusyN && !busyOk(req.data)) begin
				rejNow = REJ_BUSY;
			end else if (progOpen && !isExec(req.data) && (req.data != CMD_RESET)) begin
				rejNow = REJ_SEQ;
			end else if (isExec(req.data) && sameBlk && (progPage < lastPage)) begin
				rejNow = REJ_ORDER;
			end else if (isExec(req.data) && sameBlk && (progPage == lastPage)
			             && (partCnt == MAX_PARTIAL)) begin
				rejNow = REJ_PARTIAL;
			end else if ((req.data == CMD_ERASE_GO) && eraseOpen && badHit) begin
				rejNow = REJ_BADBLK;
			end
		end else if ((req.kind == K_RDATA) && addrPending) begin
			rejNow = REJ_EARLYRD;
		end
	end

	// Track what the flash is doing, as far as the host can tell from its own cycles.
	always_comb begin
		next_progOpen    = progOpen;
		next_eraseOpen   = eraseOpen;
		next_addrPending = addrPending;
		next_readMode    = readMode;
		next_statusMode  = statusMode;
		next_lastValid   = lastValid;
		next_lastBlk     = lastBlk;
		next_lastPage    = lastPage;
		next_partCnt     = partCnt;
		next_region      = region;
		next_addrCnt     = addrCnt;
		next_addrByte    = addrByte;
		next_rejected    = rejected;
		next_rejCode     = rejCode;
		if (acc && (req.kind == K_CMD)) begin
			next_addrCnt = 3'h0;
			case (req.data)
				CMD_READ_A: begin
					next_region = RGN_A;
					if (readMode && statusMode) begin
						next_statusMode = 1'h0;
					end else begin
						next_addrPending = 1'h1;
						next_readMode    = 1'h0;
					end
				end
				CMD_READ_B, CMD_READ_C: begin
					next_region      = (req.data == CMD_READ_B) ? RGN_B : RGN_C;
					next_addrPending = 1'h1;
					next_readMode    = 1'h0;
					next_statusMode  = 1'h0;
				end
				CMD_STATUS1, CMD_STATUS2: begin
					next_statusMode = 1'h1;
				end
				CMD_SERIAL_IN: begin
					next_progOpen = 1'h1;
					next_readMode = 1'h0;
				end
				CMD_PROG_GO, CMD_PROG_DUMMY, CMD_PROG_MULTI: begin
					next_progOpen  = 1'h0;
					next_lastValid = 1'h1;
					next_lastBlk   = progBlk;
					next_lastPage  = progPage;
					next_partCnt   = (sameBlk && (progPage == lastPage)) ? partCnt + 2'h1 : 2'h1;
				end
				CMD_ERASE_SET: begin
					next_eraseOpen = 1'h1;
					next_readMode  = 1'h0;
				end
				CMD_ERASE_GO: begin
					next_eraseOpen = 1'h0;
					if (eraseBlk == lastBlk) begin
						next_lastValid = 1'h0; // Erased block may start again from its first page.
					end
				end
				CMD_RESET: begin
					next_progOpen    = 1'h0;
					next_eraseOpen   = 1'h0;
					next_addrPending = 1'h0;
					next_readMode    = 1'h0;
					next_statusMode  = 1'h0;
				end
				default: begin
					next_readMode   = 1'h0; // Identification reads end any read.
					next_statusMode = 1'h0;
				end
			endcase
		end else if (acc && (req.kind == K_ADDR)) begin
			if (addrCnt < ADDR_CYCLES) begin
				next_addrByte[addrCnt[1:0]] = req.data;
				next_addrCnt = addrCnt + 3'h1;
			end
			if (addrPending && (addrCnt == ADDR_CYCLES - 3'h1)) begin
				next_addrPending = 1'h0;
				next_readMode    = 1'h1;
			end
		end
		// A refusal in the same cycle as a clear keeps the flag set.
		if (take && (rejNow != REJ_NONE)) begin
			next_rejected = 1'h1;
			next_rejCode  = rejNow;
		end else if (wrAcc && (paddr == REG_STATUS) && pwdata[ST_REJECT]) begin
			next_rejected = 1'h0;
		end
	end

	// Sequencer: setup, strobe low, strobe high with latches held, then release.
	// Each phase is one 100 ns cycle, which covers the flash's setup and pulse minimums.
	always_comb begin
		next_state  = state;
		next_op     = op;
		next_pins   = pins;
		next_rdData = rdData;
		next_pins.ceN = !chipSel;
		next_pins.wpN = wpAllow;
		case (state)
			ST_IDLE: begin
				if (acc) begin
					next_op     = req;
					next_state  = ST_SETUP;
					next_pins.cle     = (req.kind == K_CMD);
					next_pins.ale     = (req.kind == K_ADDR);
					next_pins.dataOe  = (req.kind != K_RDATA);
					next_pins.dataOut = req.data;
				end
			end
			ST_SETUP: begin
				next_state = ST_STROBE;
				if (op.kind == K_RDATA) begin
					next_pins.reN = 1'h0;
				end else begin
					next_pins.weN = 1'h0;
				end
			end
			ST_STROBE: begin
				next_state    = ST_HOLD;
				next_pins.weN = 1'h1;
				next_pins.reN = 1'h1;
				if (op.kind == K_RDATA) begin
					next_rdData = dataIn;
				end
			end
			ST_HOLD: begin
				next_state       = ST_IDLE;
				next_pins.cle    = 1'h0;
				next_pins.ale    = 1'h0;
				next_pins.dataOe = 1'h0;
			end
			default: begin
				next_state = ST_IDLE;
				next_pins  = PINS_IDLE;
			end
		endcase
	end

	// Bus side: control writes and the read word, latched in the setup phase.
	always_comb begin
		next_wpAllow = wpAllow;
		next_chipSel = chipSel;
		next_prdata  = prdata;
		if (wrAcc && (paddr == REG_CONTROL)) begin
			next_wpAllow = pwdata[CTL_WP];
			next_chipSel = pwdata[CTL_CE];
		end
		if (psel && !penable) begin
			next_prdata = 32'h0000_0000;
			case (paddr)
				REG_STATUS: begin
					next_prdata[ST_ENG_BUSY]        = (state != ST_IDLE);
					next_prdata[ST_DEV_READY]       = readyBusyN;
					next_prdata[ST_REJECT]          = rejected;
					next_prdata[ST_POWER_OK]        = powerDone;
					next_prdata[ST_REGION+:2]       = region;
					next_prdata[ST_PART+:2]         = partCnt;
					next_prdata[ST_CODE+:3]         = rejCode;
					next_prdata[ST_PROG_OPEN]       = progOpen;
					next_prdata[ST_STAT_MODE]       = statusMode;
				end
				REG_RDDATA:  next_prdata[7:0] = rdData;
				REG_CONTROL: next_prdata[1:0] = {chipSel, wpAllow};
				default:     next_prdata = 32'h0000_0000;
			endcase
		end
	end

	// Register every group.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			op <= '{K_CMD, 8'h00};
			pins <= PINS_IDLE;
			rdData <= 8'h00;
			prdata <= 32'h0000_0000;
			wpAllow <= 1'h0;
			chipSel <= 1'h0;
			progOpen <= 1'h0;
			eraseOpen <= 1'h0;
			addrPending <= 1'h0;
			readMode <= 1'h0;
			statusMode <= 1'h0;
			lastValid <= 1'h0;
			lastBlk <= 12'h000;
			lastPage <= 5'h00;
			partCnt <= 2'h0;
			region <= RGN_A;
			addrCnt <= 3'h0;
			addrByte <= '{default: 8'h00};
			rejected <= 1'h0;
			rejCode <= REJ_NONE;
		end else begin
			state <= next_state;
			op <= next_op;
			pins <= next_pins;
			rdData <= next_rdData;
			prdata <= next_prdata;
			wpAllow <= next_wpAllow;
			chipSel <= next_chipSel;
			progOpen <= next_progOpen;
			eraseOpen <= next_eraseOpen;
			addrPending <= next_addrPending;
			readMode <= next_readMode;
			statusMode <= next_statusMode;
			lastValid <= next_lastValid;
			lastBlk <= next_lastBlk;
			lastPage <= next_lastPage;
			partCnt <= next_partCnt;
			region <= next_region;
			addrCnt <= next_addrCnt;
			addrByte <= next_addrByte;
			rejected <= next_rejected;
			rejCode <= next_rejCode;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	cmd_known_a: assert property (state == ST_SETUP && op.kind == K_CMD |-> cmdKnown(op.data))
		else $error("Unknown command code driven");
	busy_cmd_a: assert property (take && req.kind == K_CMD && cmdKnown(req.data) && !readyBusyN
		&& !busyOk(req.data) |=> state == ST_IDLE && rejected && rejCode == REJ_BUSY)
		else $error("Command sent while flash busy");
	seq_after_a: assert property (take && req.kind == K_CMD && cmdKnown(req.data) && readyBusyN
		&& progOpen && !isExec(req.data) && req.data != CMD_RESET |=> state == ST_IDLE ##1 pins.weN)
		else $error("Illegal command after serial input");
	page_order_a: assert property (take && req.kind == K_CMD && isExec(req.data) && sameBlk
		&& progPage < lastPage && readyBusyN |=> rejected && !pins.cle [*3])
		else $error("Descending page accepted");
	spare_hold_a: assert property (region == RGN_C && !(acc && req.kind == K_CMD) |=> region == RGN_C)
		else $error("Pointer left spare region");
	partial_cap_a: assert property (acc && req.kind == K_CMD && isExec(req.data) && sameBlk
		&& progPage == lastPage |=> partCnt == $past(partCnt) + 2'h1)
		else $error("Partial program count wrong");
	early_read_a: assert property (addrPending |-> pins.reN)
		else $error("Read strobe before address complete");
	bad_erase_a: assert property (state == ST_IDLE && take && req.kind == K_CMD
		&& req.data == CMD_ERASE_GO && eraseOpen && badHit && readyBusyN && !progOpen
		|=> rejCode == REJ_BADBLK ##1 !pins.cle)
		else $error("Erase issued to bad block");
	power_hold_a: assert property (!powerDone |-> pins.weN && pins.reN && !pins.cle && !pins.ale)
		else $error("Flash touched before power settled");
	strobe_width_a: assert property ($fell(pins.weN) || $fell(pins.reN) |=> pins.weN && pins.reN
		##1 state == ST_IDLE)
		else $error("Strobe pulse not one cycle");

	issue_cmd_c: cover property (acc && req.kind == K_CMD);
	refuse_c: cover property ($rose(rejected));
	read_byte_c: cover property (state == ST_STROBE && op.kind == K_RDATA);
	resume_c: cover property (acc && req.data == CMD_READ_A && req.kind == K_CMD && statusMode);
endmodule

// *** ncc_pkg.sv ***
// Purpose: Shared constants, types and helpers for the NAND command host controller.
// Assumes: A 10 MHz clock, an 8-bit flash port and 32-bit APB data.
// Notes: Command codes, register offsets, field positions and timing counts live here only.
package ncc_pkg;
	// Clock rate and the settling time after supply ramp, rounded up to whole cycles.
	localparam int CLK_HZ         = 10_000_000;
	localparam int POWER_WAIT_US  = 200;
	localparam int POWER_WAIT_CYC = int'((longint'(POWER_WAIT_US) * CLK_HZ + 999_999) / 1_000_000);

	// Flash command set.
	localparam logic [7:0] CMD_READ_A    = 8'h00;
	localparam logic [7:0] CMD_READ_B    = 8'h01;
	localparam logic [7:0] CMD_READ_C    = 8'h50;
	localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
	localparam logic [7:0] CMD_PROG_GO   = 8'h10;
	localparam logic [7:0] CMD_PROG_DUMMY= 8'h11;
	localparam logic [7:0] CMD_PROG_MULTI= 8'h15;
	localparam logic [7:0] CMD_ERASE_SET = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO  = 8'hD0;
	localparam logic [7:0] CMD_STATUS1   = 8'h70;
	localparam logic [7:0] CMD_STATUS2   = 8'h71;
	localparam logic [7:0] CMD_ID1       = 8'h90;
	localparam logic [7:0] CMD_ID2       = 8'h91;
	localparam logic [7:0] CMD_RESET     = 8'hFF;

	// Register offsets of the controller's own APB window.
	localparam logic [11:0] REG_ISSUE   = 12'h000;
	localparam logic [11:0] REG_STATUS  = 12'h004;
	localparam logic [11:0] REG_RDDATA  = 12'h008;
	localparam logic [11:0] REG_CONTROL = 12'h00C;
	localparam logic [11:0] REG_BADBLK  = 12'h010;

	// Field positions.
	localparam int ISS_W        = 10;
	localparam int CTL_WP       = 0;
	localparam int CTL_CE       = 1;
	localparam int ST_ENG_BUSY  = 0;
	localparam int ST_DEV_READY = 1;
	localparam int ST_REJECT    = 2;
	localparam int ST_POWER_OK  = 3;
	localparam int ST_REGION    = 4;
	localparam int ST_PART      = 6;
	localparam int ST_CODE      = 8;
	localparam int ST_PROG_OPEN = 12;
	localparam int ST_STAT_MODE = 13;
	localparam int BB_MARK      = 16;

	// Geometry and sequencing limits.
	localparam int BLOCKS  = 4096;
	localparam int BLK_W   = 12;
	localparam logic [2:0] ADDR_CYCLES = 3'h4;
	localparam logic [1:0] MAX_PARTIAL = 2'h3;

	// Pointer regions.
	localparam logic [1:0] RGN_A = 2'h0;
	localparam logic [1:0] RGN_B = 2'h1;
	localparam logic [1:0] RGN_C = 2'h2;

	// Refusal codes reported in the status register.
	localparam logic [2:0] REJ_NONE    = 3'h0;
	localparam logic [2:0] REJ_UNKNOWN = 3'h1;
	localparam logic [2:0] REJ_BUSY    = 3'h2;
	localparam logic [2:0] REJ_SEQ     = 3'h3;
	localparam logic [2:0] REJ_ORDER   = 3'h4;
	localparam logic [2:0] REJ_EARLYRD = 3'h5;
	localparam logic [2:0] REJ_BADBLK  = 3'h6;
	localparam logic [2:0] REJ_PARTIAL = 3'h7;

	// Kind of one port cycle.
	typedef enum logic [1:0] {K_CMD = 2'h0, K_ADDR = 2'h1, K_WDATA = 2'h2, K_RDATA = 2'h3} ncc_kind_e;

	// Strobe sequencer states, one-hot.
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1, ST_SETUP = 4'h2, ST_STROBE = 4'h4, ST_HOLD = 4'h8
	} ncc_state_e;

	// One queued port cycle.
	typedef struct packed {
		ncc_kind_e  kind;
		logic [7:0] data;
	} ncc_op_s;

	// Every pin the controller drives toward the flash.
	typedef struct packed {
		logic       ceN;
		logic       cle;
		logic       ale;
		logic       weN;
		logic       reN;
		logic       wpN;
		logic       dataOe;
		logic [7:0] dataOut;
	} ncc_pins_s;

	// Quiet pins: deselected, strobes high, writes protected, port released.
	localparam ncc_pins_s PINS_IDLE = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 8'h00};

	// True for a code in the defined command set.
	function automatic logic cmdKnown(input logic [7:0] b);
		case (b)
			CMD_READ_A, CMD_READ_B, CMD_READ_C, CMD_SERIAL_IN, CMD_PROG_GO,
			CMD_PROG_DUMMY, CMD_PROG_MULTI, CMD_ERASE_SET, CMD_ERASE_GO,
			CMD_STATUS1, CMD_STATUS2, CMD_ID1, CMD_ID2, CMD_RESET: cmdKnown = 1'h1;
			default: cmdKnown = 1'h0;
		endcase
	endfunction

	// True for a code allowed while the flash is busy.
	function automatic logic busyOk(input logic [7:0] b);
		busyOk = (b == CMD_STATUS1) || (b == CMD_STATUS2) || (b == CMD_RESET);
	endfunction

	// True for a program-execute code.
	function automatic logic isExec(input logic [7:0] b);
		isExec = (b == CMD_PROG_GO) || (b == CMD_PROG_DUMMY) || (b == CMD_PROG_MULTI);
	endfunction
endpackage

// *** ncc_power_wait.sv ***
// Purpose: Holds off all flash access until the supply has settled.
// Assumes: Reset is released once the supply is at its working level.
// Notes: The count is a parameter so a simulation can shorten it.
`timescale 1ns/1ps
module ncc_power_wait
	import ncc_pkg::*;
	#(parameter int WAIT_CYC = POWER_WAIT_CYC)
	(
	input  wire logic mclk,
	input  wire logic sys_rst,
	output logic      done
	);
	localparam int CW = $clog2(WAIT_CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(WAIT_CYC);

	logic [CW-1:0] count;      // Cycles elapsed since reset.
	logic [CW-1:0] next_count; // Next value of the elapsed count.
	logic          next_done;  // Next value of the settled flag.

	// Count up once and then stick, so the flag never drops again.
	always_comb begin
		next_count = count;
		next_done  = done;
		if (count != LAST) begin
			next_count = count + CW'(1);
		end else begin
			next_done = 1'h1;
		end
	end

	// Register the counter.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			count <= '0;
			done  <= 1'h0;
		end else begin
			count <= next_count;
			done  <= next_done;
		end
	end
endmodule

// *** ncc_bad_blocks.sv ***
// Purpose: One flag per erase block telling whether software has marked it unusable.
// Assumes: Software marks blocks after its own screening scan.
// Notes: The table is lost on reset and must be rebuilt by software.
`timescale 1ns/1ps
module ncc_bad_blocks
	import ncc_pkg::*;
	#(parameter int NUM = BLOCKS, parameter int IW = BLK_W)
	(
	input  wire logic          mclk,
	input  wire logic          sys_rst,
	input  wire logic          wrEn,
	input  wire logic [IW-1:0] wrIdx,
	input  wire logic          wrMark,
	input  wire logic [IW-1:0] rdIdx,
	output logic               rdMark
	);
	logic [NUM-1:0] mark; // One bad flag per block.

	// Each entry loads only when addressed; a flop per entry keeps reset cheap to describe.
	for (genvar i = 0; i < NUM; i++) begin : g_entry
		always_ff @(posedge mclk) begin
			if (sys_rst) begin
				mark[i] <= 1'h0;
			end else if (wrEn && (wrIdx == IW'(i))) begin
				mark[i] <= wrMark;
			end
		end
	end

	// Lookup is combinational so the check sees the block just addressed.
	assign rdMark = mark[rdIdx];
endmodule

// *** ncc_flash_model.sv ***
// Purpose: Behavioural flash device that answers the host controller's pins.
// Assumes: Pins change only after rising mclk edges.
// Notes: Covers identity reads, status byte and a busy spell after a program.
`timescale 1ns/1ps
module ncc_flash_model
	import ncc_pkg::*;
	#(parameter logic [7:0] MAKER = 8'hA5,
	parameter logic [7:0] DEVID = 8'h3C,
	parameter logic [7:0] EXTID = 8'h5A)
	(
	input  wire ncc_pins_s  pins,
	input  wire logic       mclk,
	output logic [7:0]      dataIn,
	output logic            readyBusyN
	);
	logic [7:0] cmd     = 8'h00; // Last command latched.
	logic       idx     = 1'h0;  // Identity byte index.
	logic [7:0] last    = 8'h00; // Last byte driven.
	logic [6:0] busyCnt = 7'h00; // Remaining busy cycles.
	logic       prevWe  = 1'h1;
	logic       prevRe  = 1'h1;
	logic [2:0] addrN   = 3'h0;  // Address cycles since the last command.
	logic [7:0] val;
	// Byte offered on the next read strobe.
	always_comb begin
		if ((cmd == CMD_STATUS1) || (cmd == CMD_STATUS2)) begin
			val = {pins.wpN, readyBusyN, 6'h00};
		end else if (cmd == CMD_ID2) begin
			val = EXTID;
		end else begin
			val = idx ? DEVID : MAKER;
		end
	end
	// A released port shows the inverse of its last value, so stale data never matches.
	assign dataIn     = !pins.reN ? val : ~last;
	assign readyBusyN = (busyCnt == 7'h00);
	// Command latch on the rising write strobe; column step on the rising read strobe.
	always_ff @(posedge mclk) begin
		prevWe <= pins.weN;
		prevRe <= pins.reN;
		if (busyCnt != 7'h00) begin
			busyCnt <= busyCnt - 7'h01;
		end
		if (pins.weN && !prevWe && pins.cle && !pins.ceN) begin
			cmd   <= pins.dataOut;
			idx   <= 1'h0;
			addrN <= 3'h0;
			if (pins.dataOut == CMD_RESET) begin
				busyCnt <= 7'h00;
			end else if (pins.dataOut == CMD_PROG_GO && pins.wpN) begin
				busyCnt <= 7'h50;
			end
		end
		// Only four address cycles count; a fourth one after a read code starts a short busy spell.
		if (pins.weN && !prevWe && pins.ale && !pins.ceN) begin
			if (addrN < 3'h4) begin
				addrN <= addrN + 3'h1;
			end
			if ((addrN == 3'h3) && ((cmd == CMD_READ_A) || (cmd == CMD_READ_B)
			    || (cmd == CMD_READ_C))) begin
				busyCnt <= 7'h04;
			end
		end
		if (pins.reN && !prevRe) begin
			idx  <= 1'h1;
			last <= val;
		end
	end
endmodule

// *** test_nand_command_control.sv ***
// Purpose: Self-checking bench for the host controller against the flash model.
// Assumes: APB master tasks drive just after rising edges.
// Notes: Power wait is shortened to 5 cycles.
`timescale 1ns/1ps
module test_nand_command_control;
	import ncc_pkg::*;
	// Identity bytes are arbitrary neutral values.
	localparam logic [7:0] MK = 8'hA5, DV = 8'h3C, EX = 8'h5A;
	logic        mclk = 0, sysRst = 1, psel = 0, penable = 0, pwrite = 0;
	logic        pready, pslverr, rdyN, e, rdy;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic [7:0]  dIn;
	ncc_pins_s   pins;
	int          nMismatch = 0, checked = 0;
	always #50 mclk = ~mclk;
	ncc_host_ctrl #(.WAIT_CYC(5)) uut (.mclk(mclk), .sys_rst(sysRst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pins(pins), .dataIn(dIn), .readyBusyN(rdyN));
	ncc_flash_model #(.MAKER(MK), .DEVID(DV), .EXTID(EX)) flash (.pins(pins), .mclk(mclk),
		.dataIn(dIn), .readyBusyN(rdyN));
	// Compare and count.
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x) begin
			nMismatch++;
			$display("Error at %0t: saw %h expected %h", $time, s, x);
		end
	endtask
	// One APB transfer; pready, prdata and pslverr are read settled at the falling edge,
	// so they are the values that the next rising edge sees; only the watchdog ends a wait.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel   <= 1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		do begin
			@(negedge mclk);
			rdy = pready;
			r   = prdata;
			e   = pslverr;
			@(posedge mclk);
		end while (rdy !== 1'b1);
		psel    <= 0;
		penable <= 0;
		@(posedge mclk);
	endtask
	// One port cycle, then wait for the sequencer to drain.
	task automatic iss(input logic [1:0] k, input logic [7:0] b);
		apb(1, REG_ISSUE, {22'h0, k, b});
		do begin
			apb(0, REG_STATUS, 0);
		end while (r[ST_ENG_BUSY] !== 1'b0);
	endtask
	// One program of one page of block 0, waiting until the flash is ready again.
	task automatic prog(input logic [4:0] pg);
		iss(K_CMD, CMD_SERIAL_IN);
		iss(K_ADDR, 8'h00);
		iss(K_ADDR, {3'h0, pg});
		iss(K_ADDR, 8'h00);
		iss(K_ADDR, 8'h00);
		iss(K_WDATA, 8'hFF);
		iss(K_CMD, CMD_PROG_GO);
		do begin
			apb(0, REG_STATUS, 0);
		end while (r[ST_DEV_READY] !== 1'b1);
	endtask
	// Expect a refusal with the given code, then clear the sticky flag.
	task automatic rej(input logic [2:0] c);
		apb(0, REG_STATUS, 0);
		chk(32'({r[ST_REJECT], r[ST_CODE+:3]}), 32'({1'b1, c}));
		apb(1, REG_STATUS, 32'h4);
	endtask
	task automatic finish_test;
		$display("Comparisons %0d mismatches %0d", checked, nMismatch);
		if (nMismatch == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Watchdog: the tests need well under 5000 cycles.
	initial begin
		repeat (20000) @(posedge mclk);
		nMismatch++;
		finish_test;
	end
	initial begin
		repeat (5) @(posedge mclk);
		sysRst <= 0;
		@(posedge mclk);
		apb(0, REG_STATUS, 0);
		chk(32'(r[ST_POWER_OK]), 0);
		apb(1, REG_CONTROL, 32'h3);
		iss(K_CMD, CMD_ID1);
		iss(K_ADDR, 8'h00);
		iss(K_RDATA, 8'h00);
		apb(0, REG_RDDATA, 0);
		chk(r, 32'(MK));
		iss(K_RDATA, 8'h00);
		apb(0, REG_RDDATA, 0);
		chk(r, 32'(DV));
		iss(K_CMD, CMD_ID2);
		iss(K_ADDR, 8'h00);
		iss(K_RDATA, 8'h00);
		apb(0, REG_RDDATA, 0);
		chk(r, 32'(EX));
		iss(K_CMD, 8'h3C);
		rej(REJ_UNKNOWN);
		iss(K_CMD, CMD_READ_C);
		chk(32'(r[ST_REGION+:2]), 32'(RGN_C));
		iss(K_CMD, CMD_READ_A);
		chk(32'(r[ST_REGION+:2]), 32'(RGN_A));
		iss(K_CMD, CMD_READ_B);
		chk(32'(r[ST_REGION+:2]), 32'(RGN_B));
		iss(K_ADDR, 8'h00);
		iss(K_RDATA, 8'h00);
		rej(REJ_EARLYRD);
		iss(K_CMD, CMD_SERIAL_IN);
		iss(K_CMD, CMD_READ_A);
		rej(REJ_SEQ);
		iss(K_CMD, CMD_RESET);
		iss(K_CMD, CMD_PROG_GO);
		chk(32'(r[ST_DEV_READY]), 0);
		iss(K_CMD, CMD_READ_B);
		rej(REJ_BUSY);
		iss(K_CMD, CMD_RESET);
		chk(32'(r[ST_DEV_READY]), 1);
		iss(K_CMD, CMD_READ_A);
		repeat (5) iss(K_ADDR, 8'h00);
		iss(K_CMD, CMD_STATUS1);
		iss(K_RDATA, 8'h00);
		chk(32'(r[ST_STAT_MODE]), 1);
		apb(0, REG_RDDATA, 0);
		chk(r, 32'h0000_00C0);
		iss(K_CMD, CMD_READ_A);
		chk(32'(r[ST_STAT_MODE]), 0);
		iss(K_RDATA, 8'h00);
		chk(32'(r[ST_REJECT]), 0);
		prog(5'h01);
		prog(5'h01);
		prog(5'h01);
		chk(32'(r[ST_PART+:2]), 3);
		prog(5'h01);
		rej(REJ_PARTIAL);
		iss(K_CMD, CMD_RESET);
		prog(5'h00);
		rej(REJ_ORDER);
		iss(K_CMD, CMD_RESET);
		apb(1, REG_BADBLK, 32'h0001_0005);
		iss(K_CMD, CMD_ERASE_SET);
		iss(K_ADDR, 8'hA0);
		iss(K_ADDR, 8'h00);
		iss(K_ADDR, 8'h00);
		iss(K_CMD, CMD_ERASE_GO);
		rej(REJ_BADBLK);
		iss(K_CMD, CMD_RESET);
		apb(0, 12'h020, 0);
		chk(32'(e), 1);
		chk(r, 0);
		finish_test;
	end
endmodule
